// *** core/tct_consts.vh ***
// constants for the three channel interval timer
`ifndef TCT_CONSTS_VH
`define TCT_CONSTS_VH
`define TCT_PORT_CH0 2'h0
`define TCT_PORT_CH2 2'h2
`define TCT_PORT_CTRL 2'h3
`define TCT_CMD_HI 7
`define TCT_CMD_LO 6
`define TCT_FMT_HI 5
`define TCT_FMT_LO 4
`define TCT_MODE_HI 3
`define TCT_MODE_LO 1
`define TCT_BCD_BIT 0
`define TCT_RB_NOT_LC 5
`define TCT_RB_NOT_LS 4
`define TCT_SEL_RB 2'h3
`define TCT_FMT_LATCH 2'h0
`define TCT_FMT_LOW 2'h1
`define TCT_FMT_HIGH 2'h2
`define TCT_FMT_BOTH 2'h3
`define TCT_M0 3'h0
`define TCT_M1 3'h1
`define TCT_M2 3'h2
`define TCT_M3 3'h3
`define TCT_M4 3'h4
`define TCT_M5 3'h5
`define TCT_TICK_DIV 12
`define TCT_BIN_TOP 16'hffff
`define TCT_BCD_TOP 16'h9999
`endif

// *** core/tct_timer.v ***
// three channel interval timer with byte-wide port access
//***************************************************************
// Contract
//***************************************************************
// Contract
// - control byte: bits 7..4 command, 3..1 mode or selection, 0 format
// - format bit zero counts binary, one counts decimal; zero for read-back
// - top command bits pick counter or read-back; low bits pick access
// - mode bits 000,001,x10,x11 give modes 0,1,2,3
// - new count accepted anytime after programming without new control byte
// - latch command freezes count until read or reprogram; several allowed
// - read-back bit five zero latches count of selected counters
// - read-back bit four zero latches status; next read returns it
// - read-back bits 3,2,1 select counters 2,1,0
// - status read first, then count reads per byte format
// - status: out bit7, null bit6, format 5..4, mode 3..1, bcd bit0
// - null flag set on control or count write, cleared on load
// - counters clocked by reference oscillator divided by twelve
// - mode 0: low on control, output high N+1 ticks after write
// - mode 1: trigger starts N tick low pulse; retrigger reloads
// - mode 2: one tick low pulse every N ticks; count one illegal
// - mode 2: low gate stops and forces high; trigger reloads
// - mode 3: square wave, odd N high one tick longer
// - mode 4: count write starts; one tick low pulse N+1 after write
// - mode 5: trigger starts or restarts; expiry pulses low one tick
// - gate level sampled on tick; rising edge flag sampled then cleared
// - loaded zero acts as maximum; wraps to ffff or 9999
// - counters at ports 0..2, control byte at write-only port 3
`timescale 1ns/1ps
`include "tct_consts.vh"

module tct_timer #(
	parameter TICK_DIV = `TCT_TICK_DIV
) (
	core_clk,
	rst,
	reference_oscillator,
	port_addr,
	port_wr,
	port_rd,
	port_wdata,
	port_rdata,
	gate_input_ch0,
	gate_input_ch1,
	gate_input_ch2,
	output_ch0,
	output_ch1,
	output_ch2
);
	input wire core_clk;
	input wire rst;
	input wire reference_oscillator;
	input wire [1:0] port_addr;
	input wire port_wr;
	input wire port_rd;
	input wire [7:0] port_wdata;
	output reg [7:0] port_rdata;
	input wire gate_input_ch0;
	input wire gate_input_ch1;
	input wire gate_input_ch2;
	output wire output_ch0;
	output wire output_ch1;
	output wire output_ch2;

	//***************************************************************
	// tick divider
	//***************************************************************
	// oscillator is sampled as a level; its rising edges are divided
	reg osc_d_r;
	reg [3:0] div_r;
	reg tick_r;
	wire osc_rise = reference_oscillator & ~osc_d_r;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_d_r <= 1'b0;
			div_r <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			osc_d_r <= reference_oscillator;
			tick_r <= 1'b0;
			if (osc_rise) begin
				if (div_r == TICK_DIV - 1) begin
					div_r <= 4'h0;
					tick_r <= 1'b1;
				end else begin
					div_r <= div_r + 4'h1;
				end
			end
		end
	end

	//***************************************************************
	// decode and channels
	//***************************************************************
	wire [1:0] cmd_sel = port_wdata[`TCT_CMD_HI:`TCT_CMD_LO];
	wire is_ctrl = port_wr & (port_addr == `TCT_PORT_CTRL);
	wire is_rb = is_ctrl & (cmd_sel == `TCT_SEL_RB);
	wire [2:0] ctl_hit;
	wire [2:0] rb_hit;
	wire [2:0] wr_hit;
	wire [2:0] rd_hit;
	wire [7:0] rd_byte [0:2];
	wire [2:0] gate_in = {gate_input_ch2, gate_input_ch1, gate_input_ch0};
	wire [2:0] out_w;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : ch
			assign ctl_hit[g] = is_ctrl & (cmd_sel == g) & ~is_rb;
			assign rb_hit[g] = is_rb & port_wdata[`TCT_MODE_LO + g];
			assign wr_hit[g] = port_wr & (port_addr == g);
			assign rd_hit[g] = port_rd & (port_addr == g);
			tct_channel u_ch (
				.core_clk(core_clk),
				.rst(rst),
				.tick(tick_r),
				.ctl_wr(ctl_hit[g]),
				.rb_wr(rb_hit[g]),
				.data_wr(wr_hit[g]),
				.data_rd(rd_hit[g]),
				.wdata(port_wdata),
				.gate(gate_in[g]),
				.rdata(rd_byte[g]),
				.out_lvl(out_w[g])
			);
		end
	endgenerate
	assign output_ch0 = out_w[0];
	assign output_ch1 = out_w[1];
	assign output_ch2 = out_w[2];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_rdata <= 8'h00;
		end else if (port_rd) begin
			if (port_addr == `TCT_PORT_CTRL)
				port_rdata <= 8'h00;
			else
				port_rdata <= rd_byte[port_addr];
		end
	end
endmodule

//***************************************************************
// one counter channel
//***************************************************************
module tct_channel (
	core_clk,
	rst,
	tick,
	ctl_wr,
	rb_wr,
	data_wr,
	data_rd,
	wdata,
	gate,
	rdata,
	out_lvl
);
	input wire core_clk;
	input wire rst;
	input wire tick;
	input wire ctl_wr;
	input wire rb_wr;
	input wire data_wr;
	input wire data_rd;
	input wire [7:0] wdata;
	input wire gate;
	output wire [7:0] rdata;
	output reg out_lvl;

	reg [2:0] mode_r;
	reg [1:0] fmt_r;
	reg bcd_r;
	reg [7:0] count_input_latch_low_r;
	reg [7:0] count_input_latch_high_r;
	reg [15:0] ce_r;
	reg [15:0] olatch_r;
	reg olatched_r;
	reg [7:0] stat_r;
	reg stat_pend_r;
	reg rd_hi_r;
	reg wr_hi_r;
	reg null_r;
	reg load_pend_r;
	reg armed_r;
	reg run_r;
	reg trig_r;
	reg gate_d_r;
	reg half_r;

	wire [15:0] cin = {count_input_latch_high_r, count_input_latch_low_r};
	wire [15:0] count_output_latch_high = olatched_r ? olatch_r : ce_r;
	wire rd_high_now = (fmt_r == `TCT_FMT_HIGH) | ((fmt_r == `TCT_FMT_BOTH) & rd_hi_r);
	assign rdata = stat_pend_r ? stat_r :
		(rd_high_now ? count_output_latch_high[15:8] : count_output_latch_high[7:0]);

	// decimal aware decrement, wraps zero to top of format
	function [15:0] dec_by;
		input [15:0] v;
		input bcd;
		input [1:0] step;
		reg [15:0] r;
		integer i;
		begin
			r = v;
			for (i = 0; i < 2; i = i + 1) begin
				if (i < step) begin
					if (!bcd) begin
						r = r - 16'h0001;
					end else if (r == 16'h0000) begin
						r = `TCT_BCD_TOP;
					end else if (r[3:0] != 4'h0) begin
						r = r - 16'h0001;
					end else if (r[7:4] != 4'h0) begin
						r = {r[15:8], r[7:4] - 4'h1, 4'h9};
					end else if (r[11:8] != 4'h0) begin
						r = {r[15:12], r[11:8] - 4'h1, 8'h99};
					end else begin
						r = {r[15:12] - 4'h1, 12'h999};
					end
				end
			end
			dec_by = r;
		end
	endfunction

	wire [2:0] mode_dec = wdata[`TCT_MODE_HI] & ~wdata[`TCT_MODE_HI - 1] ?
		{1'b1, 1'b0, wdata[`TCT_MODE_LO]} :
		(wdata[`TCT_MODE_HI - 1] ? {1'b0, 1'b1, wdata[`TCT_MODE_LO]} :
		{2'b00, wdata[`TCT_MODE_LO]});
	wire sq = (mode_r == `TCT_M3);
	wire periodic = (mode_r == `TCT_M2) | sq;
	wire [1:0] step = (sq ? 2'h2 : 2'h1);
	// odd square-wave count: drop one extra tick in the low half
	wire [15:0] sq_load = {cin[15:1], 1'b0};
	wire gate_rise = gate & ~gate_d_r;
	wire [15:0] ce_dec = dec_by(ce_r, bcd_r, step);
	wire at_one = (ce_r == 16'h0001);
	wire at_two = (ce_r == 16'h0002);
	wire sq_end = sq & (at_two | (ce_r == 16'h0000 & cin[0] == 1'b0 & 1'b0));
	wire write_done = data_wr & ((fmt_r != `TCT_FMT_BOTH) | wr_hi_r);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_r <= `TCT_M0;
			fmt_r <= `TCT_FMT_LOW;
			bcd_r <= 1'b0;
			count_input_latch_low_r <= 8'h00;
			count_input_latch_high_r <= 8'h00;
			ce_r <= 16'h0000;
			olatch_r <= 16'h0000;
			olatched_r <= 1'b0;
			stat_r <= 8'h00;
			stat_pend_r <= 1'b0;
			rd_hi_r <= 1'b0;
			wr_hi_r <= 1'b0;
			null_r <= 1'b1;
			load_pend_r <= 1'b0;
			armed_r <= 1'b0;
			run_r <= 1'b0;
			trig_r <= 1'b0;
			gate_d_r <= 1'b0;
			half_r <= 1'b0;
			out_lvl <= 1'b0;
		end else begin
			gate_d_r <= gate;
			if (gate_rise)
				trig_r <= 1'b1;
			// ---- port side ----
			if (ctl_wr && wdata[`TCT_FMT_HI:`TCT_FMT_LO] == `TCT_FMT_LATCH) begin
				if (!olatched_r) begin
					olatched_r <= 1'b1;
					olatch_r <= ce_r;
				end
			end else if (ctl_wr) begin
				fmt_r <= wdata[`TCT_FMT_HI:`TCT_FMT_LO];
				mode_r <= mode_dec;
				bcd_r <= wdata[`TCT_BCD_BIT];
				null_r <= 1'b1;
				olatched_r <= 1'b0;
				stat_pend_r <= 1'b0;
				rd_hi_r <= 1'b0;
				wr_hi_r <= 1'b0;
				load_pend_r <= 1'b0;
				armed_r <= 1'b0;
				run_r <= 1'b0;
				half_r <= 1'b0;
				out_lvl <= (mode_dec != `TCT_M0);
			end
			if (rb_wr) begin
				if (!wdata[`TCT_RB_NOT_LC] && !olatched_r) begin
					olatched_r <= 1'b1;
					olatch_r <= ce_r;
				end
				if (!wdata[`TCT_RB_NOT_LS] && !stat_pend_r) begin
					stat_pend_r <= 1'b1;
					stat_r <= {out_lvl, null_r, fmt_r, mode_r, bcd_r};
				end
			end
			if (data_rd) begin
				if (stat_pend_r) begin
					stat_pend_r <= 1'b0;
				end else if (fmt_r == `TCT_FMT_BOTH && !rd_hi_r) begin
					rd_hi_r <= 1'b1;
				end else begin
					rd_hi_r <= 1'b0;
					olatched_r <= 1'b0;
				end
			end
			if (data_wr) begin
				null_r <= 1'b1;
				if (fmt_r == `TCT_FMT_HIGH || (fmt_r == `TCT_FMT_BOTH && wr_hi_r))
					count_input_latch_high_r <= wdata;
				else
					count_input_latch_low_r <= wdata;
				if (fmt_r == `TCT_FMT_LOW)
					count_input_latch_high_r <= 8'h00;
				if (fmt_r == `TCT_FMT_HIGH)
					count_input_latch_low_r <= 8'h00;
				wr_hi_r <= (fmt_r == `TCT_FMT_BOTH) & ~wr_hi_r;
				if (fmt_r == `TCT_FMT_BOTH && !wr_hi_r && mode_r == `TCT_M0)
					out_lvl <= 1'b0;
			end
			if (write_done) begin
				armed_r <= 1'b1;
				if (mode_r == `TCT_M0 || mode_r == `TCT_M4 || !run_r)
					load_pend_r <= 1'b1;
				if (mode_r == `TCT_M0)
					out_lvl <= 1'b0;
			end
			if (periodic && !gate)
				out_lvl <= 1'b1;
			// ---- tick side ----
			if (tick && !data_wr && !ctl_wr) begin
				trig_r <= gate_rise;
				if ((mode_r == `TCT_M1 || mode_r == `TCT_M5) && trig_r && armed_r) begin
					ce_r <= cin;
					null_r <= 1'b0;
					run_r <= 1'b1;
					load_pend_r <= 1'b0;
					if (mode_r == `TCT_M1)
						out_lvl <= 1'b0;
				end else if (periodic && trig_r && armed_r) begin
					ce_r <= sq ? sq_load : cin;
					null_r <= 1'b0;
					run_r <= 1'b1;
					half_r <= 1'b0;
					load_pend_r <= 1'b0;
				end else if (load_pend_r) begin
					ce_r <= sq ? sq_load : cin;
					null_r <= 1'b0;
					load_pend_r <= 1'b0;
					run_r <= 1'b1;
					half_r <= 1'b0;
				end else if (run_r) begin
					case (mode_r)
						`TCT_M0: begin
							if (gate) begin
								ce_r <= ce_dec;
								if (at_one)
									out_lvl <= 1'b1;
							end
						end
						`TCT_M1: begin
							ce_r <= ce_dec;
							if (at_one) begin
								out_lvl <= 1'b1;
								run_r <= 1'b0;
							end
						end
						`TCT_M2: begin
							if (gate) begin
								if (at_one) begin
									out_lvl <= 1'b1;
									ce_r <= cin;
									null_r <= 1'b0;
								end else begin
									ce_r <= ce_dec;
									out_lvl <= ~(ce_r == 16'h0002);
								end
							end
						end
						`TCT_M3: begin
							if (gate) begin
								if (at_two || sq_end) begin
									half_r <= ~half_r;
									out_lvl <= half_r;
									null_r <= 1'b0;
									// high half holds one extra tick for odd count
									ce_r <= (!half_r && cin[0]) ? cin - 16'h0001 :
										(half_r && cin[0]) ? cin + 16'h0001 : sq_load;
								end else begin
									ce_r <= ce_dec;
								end
							end
						end
						`TCT_M4, `TCT_M5: begin
							if (gate) begin
								ce_r <= ce_dec;
								if (at_one)
									out_lvl <= 1'b0;
							end
							if (!out_lvl) begin
								out_lvl <= 1'b1;
								run_r <= 1'b0;
							end
						end
						default: begin
							ce_r <= ce_dec;
						end
					endcase
				end
			end
		end
	end
endmodule

// *** verif/tb_three_channel_interval_timer.sv ***
// self-checking bench for the interval timer
`timescale 1ns/1ps
module tb_three_channel_interval_timer;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic reference_oscillator = 1'b0;
	logic [2:0] gate = 3'h7;
	wire [1:0] port_addr;
	wire port_wr;
	wire port_rd;
	wire [7:0] port_wdata;
	wire [7:0] port_rdata;
	wire [2:0] outs;
	int miscompares = 0;
	int n_compared = 0;
	int n;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [15:0] v1;
	logic [7:0] sq [2] = '{8'h06, 8'h05};
	logic [7:0] m45 [2] = '{8'h9a, 8'h98};
	tct_timer #(.TICK_DIV(4)) dut_u (.core_clk(core_clk), .rst(rst),
		.reference_oscillator(reference_oscillator), .port_addr(port_addr),
		.port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata),
		.port_rdata(port_rdata), .gate_input_ch0(gate[0]), .gate_input_ch1(gate[1]),
		.gate_input_ch2(gate[2]), .output_ch0(outs[0]), .output_ch1(outs[1]),
		.output_ch2(outs[2]));
	tct_sw_model sw_u (.core_clk(core_clk), .port_rdata(port_rdata), .port_addr(port_addr),
		.port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata));
	initial forever #4 core_clk = ~core_clk;
	// one tick every 8 core clocks with a divider of 4
	always @(negedge core_clk) reference_oscillator <= ~reference_oscillator;
	task finish_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wait_out(input int ch, input logic lvl, input int lim);
		n = 0;
		while (outs[ch] !== lvl) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > lim) begin
				miscompares++;
				$display("[ERR] out%0d expected %b seen %b", ch, lvl, outs[ch]);
				finish_test();
			end
		end
	endtask
	task t_rate();
		sw_u.wr(2'h3, 8'hb4);
		sw_u.wr(2'h2, 8'h04);
		sw_u.wr(2'h2, 8'h00);
		wait_out(2, 1'b0, 200);
		wait_out(2, 1'b1, 200);
		chk("rate low", 16'h8, n[15:0]);
		wait_out(2, 1'b0, 200);
		chk("rate high", 16'h18, n[15:0]);
		sw_u.wr(2'h3, 8'he8);
		sw_u.rd(2'h2, b0);
		chk("status ch2", 16'h34, {8'h0, b0 & 8'h7f});
		sw_u.rd(2'h3, b0);
		chk("ctrl port read", 16'h0, {8'h0, b0});
		gate[2] = 1'b0;
		wait_out(2, 1'b1, 2);
		repeat (40) @(negedge core_clk);
		chk("gated output_ch2", 16'h1, {15'h0, outs[2]});
		gate[2] = 1'b1;
	endtask
	task t_square();
		sw_u.wr(2'h3, 8'h16);
		foreach (sq[i]) begin
			sw_u.wr(2'h0, sq[i]);
			repeat (3) begin
				wait_out(0, 1'b0, 400);
				wait_out(0, 1'b1, 400);
			end
			chk("square low", {8'h0, 8'h8 * (sq[i] >> 1)}, n[15:0]);
			wait_out(0, 1'b0, 400);
			chk("square high", {8'h0, 8'h8 * ((sq[i] + 8'h1) >> 1)}, n[15:0]);
		end
	endtask
	task t_latch();
		sw_u.wr(2'h3, 8'h72);
		chk("mode1 out1", 16'h1, {15'h0, outs[1]});
		sw_u.wr(2'h3, 8'h70);
		sw_u.wr(2'h3, 8'he4);
		sw_u.rd(2'h1, b0);
		chk("status ch1", 16'h70, {8'h0, b0});
		sw_u.wr(2'h1, 8'h00);
		sw_u.wr(2'h1, 8'h01);
		repeat (80) @(negedge core_clk);
		sw_u.wr(2'h3, 8'h40);
		repeat (40) @(negedge core_clk);
		sw_u.rd(2'h1, b0);
		sw_u.rd(2'h1, b1);
		v1 = {b1, b0};
		sw_u.wr(2'h3, 8'h40);
		sw_u.rd(2'h1, b0);
		sw_u.rd(2'h1, b1);
		v1 = v1 - {b1, b0};
		chk("latch freeze", 16'h1, {15'h0, v1 >= 16'h4 && v1 <= 16'h7});
		chk("out1 low", 16'h0, {15'h0, outs[1]});
		wait_out(1, 1'b1, 2200);
	endtask
	task t_strobe();
		foreach (m45[i]) begin
			@(negedge core_clk);
			gate[2] = 1'b0;
			sw_u.wr(2'h3, m45[i]);
			sw_u.wr(2'h2, 8'h03);
			repeat (40) @(negedge core_clk);
			chk("strobe idle", 16'h1, {15'h0, outs[2]});
			gate[2] = 1'b1;
			wait_out(2, 1'b0, 100);
			wait_out(2, 1'b1, 20);
			chk("strobe width", 16'h8, n[15:0]);
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		t_rate();
		t_square();
		t_latch();
		t_strobe();
		finish_test();
	end
endmodule

// *** verif/tct_sw_model.sv ***
// processor software model on the byte-wide ports
`timescale 1ns/1ps
module tct_sw_model (
	input wire core_clk,
	input wire [7:0] port_rdata,
	output logic [1:0] port_addr = 2'h0,
	output logic port_wr = 1'b0,
	output logic port_rd = 1'b0,
	output logic [7:0] port_wdata = 8'h0
);
	// gap first so back-to-back writes never reassign the strobe in one step
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge core_clk);
		port_addr = a;
		port_wdata = d;
		port_wr = 1'b1;
		@(negedge core_clk);
		port_wr = 1'b0;
		port_wdata = ~d;
	endtask
	// called at a falling edge
	task rd(input logic [1:0] a, output logic [7:0] d);
		port_addr = a;
		port_rd = 1'b1;
		@(negedge core_clk);
		port_rd = 1'b0;
		@(negedge core_clk);
		d = port_rdata;
	endtask
endmodule

// *** verif/tct_timer_monitor.sv ***
// port checker for the interval timer
`timescale 1ns/1ps
module tct_timer_monitor #(
	parameter TICK_DIV = 12
) (
	input wire core_clk,
	input wire rst,
	input wire reference_oscillator,
	input wire [1:0] port_addr,
	input wire port_wr,
	input wire port_rd,
	input wire [7:0] port_wdata,
	input wire [7:0] port_rdata,
	input wire gate_input_ch0,
	input wire gate_input_ch1,
	input wire gate_input_ch2,
	input wire output_ch0,
	input wire output_ch1,
	input wire output_ch2
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// limitation: tick width assumes the oscillator toggles every core clock
	wire ctl = port_wr && port_addr == 2'h3 && port_wdata[5:4] != 2'h0;
	wire [1:0] sel = port_wdata[7:6];
	wire rbst = port_wr && port_addr == 2'h3 && port_wdata[7:4] == 4'he && port_wdata[3];
	reg [5:0] ctl2_r;
	reg [7:0] low_r;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctl2_r <= 6'h0;
			low_r <= 8'h0;
		end else begin
			if (ctl && sel == 2'h2)
				ctl2_r <= port_wdata[5:0];
			low_r <= (ctl2_r[2:1] == 2'h2 && gate_input_ch2 && !output_ch2) ? low_r + 8'h1 : 8'h0;
		end
	end
	chk_ctrl_port_zero: assert property (port_rd && port_addr == 2'h3 ##1 !port_rd
		|=> port_rdata == 8'h0) else $error("control port read not zero");
	chk_rdata_hold: assert property (!port_rd [*3] |=> $stable(port_rdata))
		else $error("read data moved without a read");
	chk_m0_ctl_low: assert property (ctl && sel == 2'h1 && port_wdata[3:1] == 3'h0
		|-> ##[1:2] !output_ch1) else $error("mode 0 control did not drive low");
	chk_m1_ctl_high: assert property (ctl && sel == 2'h1 && port_wdata[3:1] == 3'h1
		|-> ##[1:2] output_ch1) else $error("mode 1 control did not drive high");
	chk_ch2_ctl_high: assert property (ctl && sel == 2'h2 && port_wdata[3:1] != 3'h0
		&& port_wdata[3:1] != 3'h4 |-> ##[1:2] output_ch2) else $error("control not high");
	// mode bits sit at ctl2_r[3:1]; x1x is the rate or square family
	chk_gate_force_high: assert property (ctl2_r[2] == 1'b1 && !gate_input_ch2
		|-> ##[1:2] output_ch2) else $error("low gate did not force high");
	chk_pulse_one_tick: assert property (low_r <= 2 * TICK_DIV)
		else $error("rate pulse longer than one tick");
	chk_status_byte: assert property (rbst ##1 port_rd && port_addr == 2'h2
		|=> ##1 port_rdata[5:0] == ctl2_r) else $error("status byte wrong");
endmodule
bind tct_timer tct_timer_monitor #(.TICK_DIV(TICK_DIV)) mon_u (.core_clk, .rst,
	.reference_oscillator, .port_addr, .port_wr, .port_rd, .port_wdata, .port_rdata,
	.gate_input_ch0, .gate_input_ch1, .gate_input_ch2, .output_ch0, .output_ch1, .output_ch2);
